/* File: src/aprc_params.svh */
/*
  Constants for the converter readout control: counts, widths, reset values.
  Assumes a 100 MHz master clock; included by bare name from the design.
*/
`ifndef APRC_PARAMS_SVH
`define APRC_PARAMS_SVH

`define APRC_CLK_PERIOD_NS   10
`define APRC_WORD_W          16
`define APRC_CONV_CYCLES     64
`define APRC_SEQ_W           6
`define APRC_SEQ_LAST        6'h3F
`define APRC_PULSE_FIRST     6'h3D
`define APRC_PULSE_LAST      6'h3E
`define APRC_SETTLE_CYCLES   8192
`define APRC_SETTLE_W        14
`define APRC_CAL_CYCLES      256
`define APRC_CAL_W           14
`define APRC_WORD_RST        16'h0000
`define APRC_CAL_OFFSET_RST  16'h0000
`define APRC_CAL_GAIN_RST    16'h0000
`define APRC_CAL_GAIN_UNITY  16'h8000

`endif

/* File: src/aprc_pkg.sv */
/*
  Types for the converter readout control.
  Assumes the constants header is compiled alongside.
*/
package aprc_pkg;

  // Sequencing states, one-hot
  typedef enum logic [3:0] {
    APRC_ST_HOLD   = 4'h1,
    APRC_ST_SETTLE = 4'h2,
    APRC_ST_RUN    = 4'h4,
    APRC_ST_CAL    = 4'h8
  } aprc_state_t;

endpackage

/* File: src/aprc_readout.sv */
/*
  Control and parallel readout of an oversampling converter: calibrate request,
  calibration clear, sequencer synchronisation, valid flag and 16-bit host port.
  Assumes filter_word and overrange come from logic on mclk; every other input
  is a pin and is synchronised here.
*/
`timescale 1ns/100ps
`include "aprc_params.svh"

// Summary of operation
// [R01] A one-cycle high calibrate request starts a gain and offset calibration.
// [R02] Calibration clear asynchronously wipes stored offset and gain values.
// [R03] Rising edge of calibration clear pulses the modulator integrator discharge.
// [R04] Calibration clear otherwise acts exactly like the synchronisation input.
// [R05] Controller pulses synchronisation after power-up so shared-clock devices align.
// [R06] Chip select sampled each clock; bus drives only if select and read low.
// [R07] Read strobe sampled each clock and combined with chip select for reads.
// [R08] Either select or read sampled high puts all sixteen lines in high impedance.
// [R09] In serial mode the controller holds chip select low permanently.
// [R10] Synchronisation rising edge clears the filter sequencer counter to zero.
// [R11] Reset state releases when synchronisation samples low; ready goes high then.
// [R12] Valid flag drops at synchronisation and rises 8192 cycles after release.
// [R13] Ready falls 64 cycles after valid rises, marking a readable word.
// [R14] Each newly available word is signalled by a falling ready edge.
// [R15] Ready returns high when a read of the word completes.
// [R16] Without a read, ready pulses high two cycles before the next update.
// [R17] Ready marks first results after calibration like after synchronisation.
// [R18] Word MSB appears on the highest-numbered bus line.
// [R19] Port select high picks the parallel interface, low the serial one.
// [R20] Valid flag low 8192 cycles on overrange, calibration, synchronisation, reset.
// [R21] Word LSB appears on the lowest-numbered bus line.
// [R22] Output word updates once every 64 clock cycles in steady operation.
// [R23] Calibration length is a parameter; ready stays high until it ends.
module aprc_readout
  import aprc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `APRC_SETTLE_CYCLES,  // Valid flag settle count
  parameter int CAL_CYCLES    = `APRC_CAL_CYCLES      // Calibration sequence length
) (
  input  wire logic        mclk,               // Master clock, 100 MHz
  input  wire logic        reset_n,            // Block reset, async, active low
  input  wire logic        port_sel,           // Pin: high parallel, low serial
  input  wire logic        cal_req,            // Pin: calibrate request
  input  wire logic        sync_in,            // Pin: sequencer synchronisation
  input  wire logic        cal_clear,          // Pin: calibration clear, async
  input  wire logic        cs_n,               // Pin: chip select, active low
  input  wire logic        rd_n,               // Pin: read strobe, active low
  input  wire logic        overrange,          // Modulator overrange, mclk domain
  input  wire logic [15:0] filter_word,        // Filter result, mclk domain
  output logic      [15:0] output_bus,         // Data lines, bit 15 is MSB
  output logic             output_bus_oe,      // High while the bus is driven
  output logic             word_ready_n,       // Word ready, active low
  output logic             result_valid_flag,  // Result is valid
  output logic             modulator_clear     // Integrator discharge pulse
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_m_q;
  logic [NSYNC-1:0] pin_s_q;
  logic             clr_s_prev_q;

  assign pin_raw = {port_sel, cal_req, sync_in, cal_clear, cs_n, rd_n};

  // Two flops per pin; only the second stage is ever read by logic
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          pin_m_q[gi] <= 1'b1;
          pin_s_q[gi] <= 1'b1;
        end else begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_s_q[gi] <= pin_m_q[gi];
        end
      end
    end
  endgenerate

  wire par_s   = pin_s_q[5];  // [R19]
  wire calr_s  = pin_s_q[4];
  wire sync_s  = pin_s_q[3];
  wire clr_s   = pin_s_q[2];
  wire cs_n_s  = pin_s_q[1];
  wire rd_n_s  = pin_s_q[0];

  // ----------------------------------------------------------------------
  // Decoded events
  // ----------------------------------------------------------------------
  aprc_state_t                  state_q;
  aprc_state_t                  state_d;
  logic [`APRC_SEQ_W-1:0]       seq_cnt_q;
  logic [`APRC_SETTLE_W-1:0]    valid_cnt_q;
  logic [`APRC_CAL_W-1:0]       cal_cnt_q;
  logic                         calr_prev_q;
  logic                         rd_act_q;
  logic [15:0]                  word_q;
  logic [15:0]                  cal_offset_q;
  logic [15:0]                  cal_gain_q;

  // Clear behaves as a sync as well; both hold the reset state while high
  wire hold_w     = sync_s | clr_s;                                       // [R04]
  wire cal_start  = calr_s & ~calr_prev_q &
                    (state_q == APRC_ST_RUN || state_q == APRC_ST_SETTLE); // [R01]
  wire cal_done   = (state_q == APRC_ST_CAL) &&
                    (cal_cnt_q == `APRC_CAL_W'(CAL_CYCLES - 1));          // [R23]
  wire release_w  = (state_q == APRC_ST_HOLD) && !hold_w;                 // [R11]
  wire restart_w  = release_w | cal_done;                                 // [R17]
  wire rd_act_w   = par_s & ~cs_n_s & ~rd_n_s;                            // [R06] [R07]
  wire rd_done_w  = rd_act_q & ~rd_act_w;                                 // [R15]
  wire update_w   = (state_q == APRC_ST_RUN || state_q == APRC_ST_SETTLE) &&
                    (seq_cnt_q == `APRC_SEQ_LAST);                        // [R22]
  wire pulse_w    = (state_q == APRC_ST_RUN) &&
                    (seq_cnt_q == `APRC_PULSE_FIRST ||
                     seq_cnt_q == `APRC_PULSE_LAST);                      // [R16]
  wire first_w    = (state_q == APRC_ST_SETTLE) && update_w && result_valid_flag; // [R13]
  wire new_word_w = first_w || (state_q == APRC_ST_RUN && update_w);      // [R14]
  wire [15:0] corr_word = filter_word - cal_offset_q;

  // ----------------------------------------------------------------------
  // Sequencing state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      APRC_ST_HOLD:   if (!hold_w) state_d = APRC_ST_SETTLE;
      APRC_ST_SETTLE: if (first_w) state_d = APRC_ST_RUN;
      APRC_ST_RUN:    if (cal_start) state_d = APRC_ST_CAL;
      APRC_ST_CAL:    if (cal_done) state_d = APRC_ST_SETTLE;
      default:        state_d = APRC_ST_HOLD;
    endcase
    if (state_q == APRC_ST_SETTLE && cal_start) state_d = APRC_ST_CAL;
    if (hold_w) state_d = APRC_ST_HOLD;                                    // [R10]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) state_q <= APRC_ST_HOLD;
    else          state_q <= state_d;
  end

  // Filter sequencer: zero while held or calibrating, wraps every 64 cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)                                             seq_cnt_q <= '0;
    else if (hold_w || state_q == APRC_ST_HOLD || restart_w)  seq_cnt_q <= '0; // [R10]
    else if (state_q == APRC_ST_CAL)                          seq_cnt_q <= '0;
    else                                                      seq_cnt_q <= seq_cnt_q + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Valid flag: settle counter reloaded by every disturbing event
  // ----------------------------------------------------------------------
  wire valid_load = restart_w | overrange | cal_start;                    // [R20]
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      valid_cnt_q       <= `APRC_SETTLE_W'(SETTLE_CYCLES - 1);
      result_valid_flag <= 1'b0;
    end else begin
      if (valid_load)              valid_cnt_q <= `APRC_SETTLE_W'(SETTLE_CYCLES - 1);
      else if (valid_cnt_q != '0)  valid_cnt_q <= valid_cnt_q - 1'b1;
      // Counter reloads at release so the 8192 run from release exactly
      result_valid_flag <= !hold_w && state_q != APRC_ST_HOLD && state_q != APRC_ST_CAL &&
                           !valid_load && valid_cnt_q == '0;               // [R12]
    end
  end

  // ----------------------------------------------------------------------
  // Calibration: timed sequence, values wiped asynchronously by the clear pin
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cal_cnt_q   <= '0;
      calr_prev_q <= 1'b1;  // Matches the synchroniser's reset level: no false request edge
    end else begin
      calr_prev_q <= calr_s;
      if (state_q == APRC_ST_CAL) cal_cnt_q <= cal_cnt_q + 1'b1;
      else                        cal_cnt_q <= '0;
    end
  end

  // The raw pin is the async clear: a clear is never missed, even without clock
  always_ff @(posedge mclk or negedge reset_n or posedge cal_clear) begin
    if (!reset_n || cal_clear) begin
      cal_offset_q <= `APRC_CAL_OFFSET_RST;                                // [R02]
      cal_gain_q   <= `APRC_CAL_GAIN_RST;
    end else if (cal_done) begin
      cal_offset_q <= filter_word;                                         // [R01]
      cal_gain_q   <= `APRC_CAL_GAIN_UNITY;
    end
  end

  // Integrator discharge on the rising edge of the clear pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clr_s_prev_q    <= 1'b1;  // Synchroniser resets high; a low here would fake a clear edge
      modulator_clear <= 1'b0;
    end else begin
      clr_s_prev_q    <= clr_s;
      modulator_clear <= clr_s & ~clr_s_prev_q;                            // [R03]
    end
  end

  // ----------------------------------------------------------------------
  // Host port: word register, bus enable and ready
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_q        <= `APRC_WORD_RST;
      output_bus    <= `APRC_WORD_RST;
      output_bus_oe <= 1'b0;
      rd_act_q      <= 1'b0;
    end else begin
      rd_act_q      <= rd_act_w;
      if (update_w) word_q <= corr_word;                                   // [R22]
      output_bus    <= update_w ? corr_word : word_q;                      // [R18] [R21]
      output_bus_oe <= rd_act_w;                                           // [R06] [R08]
    end
  end

  // Ready: set wins over the fall only when no new word lands that cycle
  wire ready_n_d = !par_s                         ? 1'b1 :
                   (state_q != APRC_ST_RUN && !first_w) ? 1'b1 :           // [R11] [R23]
                   new_word_w                     ? 1'b0 :                 // [R14]
                   (rd_done_w || pulse_w)         ? 1'b1 :                 // [R15] [R16]
                   word_ready_n;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) word_ready_n <= 1'b1;
    else          word_ready_n <= ready_n_d;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [`APRC_SETTLE_W:0] since_rel_q;
  logic [`APRC_SETTLE_W:0] since_load_q;
  logic [`APRC_SEQ_W:0]    gap_q;
  // Cycles since restart and since valid reload; saturate so long runs never alias
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      since_rel_q  <= '0;
      since_load_q <= '0;
      gap_q        <= '0;
    end else begin
      since_rel_q  <= restart_w ? '0 : (&since_rel_q ? since_rel_q : since_rel_q + 1'b1);
      since_load_q <= valid_load ? '0 : (&since_load_q ? since_load_q : since_load_q + 1'b1);
      gap_q        <= update_w ? (`APRC_SEQ_W+1)'(1) : gap_q + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_two_high;
    word_ready_n ##1 (word_ready_n || state_q != APRC_ST_RUN);
  endsequence

  chk_release_ready_high: assert property (release_w && par_s |=> word_ready_n) // [R11]
    else $error("ready not high at release");
  chk_valid_low_release: assert property (restart_w |=> !result_valid_flag [*2]) // [R12]
    else $error("valid flag not low after release");
  chk_valid_settle_count: assert property ($rose(result_valid_flag) |-> since_load_q == SETTLE_CYCLES) // [R12]
    else $error("valid flag rose at wrong count");
  chk_ready_fall_update: assert property ($fell(word_ready_n) |-> $past(new_word_w)) // [R14]
    else $error("ready fell without a new word");
  chk_first_word_gap: assert property (since_rel_q == SETTLE_CYCLES + 63 && state_q == APRC_ST_SETTLE // [R13]
                                       && result_valid_flag && par_s |=> !word_ready_n)
    else $error("first word not flagged 64 cycles after valid");
  chk_read_sets_ready: assert property (rd_done_w && !new_word_w && par_s |=> word_ready_n) // [R15]
    else $error("ready not raised by read");
  chk_unread_pulse: assert property (state_q == APRC_ST_RUN && seq_cnt_q == `APRC_PULSE_FIRST && par_s // [R16]
                                     && !hold_w |=> s_two_high)
    else $error("no two-cycle ready pulse");
  chk_bus_enable_pins: assert property (output_bus_oe |-> $past(!cs_n_s && !rd_n_s && par_s)) // [R06] [R08]
    else $error("bus driven without select and read");
  chk_cal_values_clear: assert property (clr_s |-> cal_offset_q == `APRC_CAL_OFFSET_RST) // [R02]
    else $error("calibration values not cleared");
  chk_mod_clear_pulse: assert property ($rose(clr_s) |=> modulator_clear ##1 !modulator_clear) // [R03]
    else $error("modulator clear pulse wrong");
  chk_overrange_valid: assert property (overrange |=> !result_valid_flag) // [R20]
    else $error("valid flag high after overrange");
  chk_cal_ready_high: assert property (state_q == APRC_ST_CAL |=> word_ready_n) // [R23]
    else $error("ready low during calibration");
  chk_update_period: assert property (update_w && state_q == APRC_ST_RUN && gap_q != '0 // [R22]
                                      && $past(state_q) == APRC_ST_RUN |-> gap_q == 7'h40)
    else $error("update period not 64");
  chk_seq_cleared: assert property (hold_w |=> seq_cnt_q == '0) // [R10]
    else $error("sequencer not cleared");

endmodule // aprc_readout

/* File: verification/aprc_host_model.sv */
/*
  Host processor model that reads the converter's parallel port.
  Assumes one mclk domain; the bench asks for a read on rd_req and waits for rd_done.
*/
`timescale 1ns/100ps
module aprc_host_model (
  input  wire logic        mclk,           // Master clock
  input  wire logic        reset_n,        // Async reset, active low
  input  wire logic        port_sel,       // High for parallel mode
  input  wire logic        rd_req,         // Bench asks for one read
  input  wire logic [15:0] output_bus,     // Device data lines
  input  wire logic        output_bus_oe,  // Device drives the lines
  output logic             cs_n,           // Chip select, active low
  output logic             rd_n,           // Read strobe, active low
  output logic             rd_done,        // Word captured
  output logic      [15:0] rd_word         // Captured word
);
  logic [15:0] last_q;  // Last value seen driven
  // A released bus must not show the old word, so it reads back inverted
  wire  [15:0] bus_seen = output_bus_oe ? output_bus : ~last_q;

  // Read cycle: strobes held low until the device drives, then released
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      rd_done <= 1'b0;
      rd_word <= 16'h0000;
      last_q  <= 16'h0000;
    end else begin
      if (output_bus_oe) last_q <= output_bus;
      if (!rd_req) begin
        rd_n    <= 1'b1;
        rd_done <= 1'b0;
        cs_n    <= port_sel;
      end else if (!rd_done && !rd_n && output_bus_oe) begin
        rd_word <= bus_seen;
        rd_done <= 1'b1;
        cs_n    <= port_sel;
        rd_n    <= 1'b1;
      end else if (!rd_done) begin
        cs_n <= 1'b0;
        rd_n <= 1'b0;
      end
    end
  end
endmodule // aprc_host_model

/* File: verification/tb_top.sv */
/*
  Self-checking bench for the converter readout control.
  Assumes the host model on the parallel port; settle count shrunk to 128.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int SETTLE = 128;  // Shrunk valid settle count, multiple of 64
  logic mclk = 1'b0, reset_n = 1'b0, port_sel = 1'b1, cal_req = 1'b0, sync_in = 1'b0;
  logic cal_clear = 1'b0, overrange = 1'b0, rd_req = 1'b0, mod_seen = 1'b0;
  logic [15:0] filter_word = 16'h8001;
  logic [15:0] output_bus, rd_word;
  logic cs_n, rd_n, rd_done, output_bus_oe, word_ready_n, result_valid_flag, modulator_clear;
  int num_errors = 0, comparisons = 0, n = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (modulator_clear === 1'b1) mod_seen <= 1'b1;

  aprc_readout #(.SETTLE_CYCLES(SETTLE), .CAL_CYCLES(8)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .port_sel(port_sel), .cal_req(cal_req), .sync_in(sync_in),
    .cal_clear(cal_clear), .cs_n(cs_n), .rd_n(rd_n), .overrange(overrange),
    .filter_word(filter_word), .output_bus(output_bus), .output_bus_oe(output_bus_oe),
    .word_ready_n(word_ready_n), .result_valid_flag(result_valid_flag),
    .modulator_clear(modulator_clear));
  aprc_host_model u_host (
    .mclk(mclk), .reset_n(reset_n), .port_sel(port_sel), .rd_req(rd_req), .output_bus(output_bus),
    .output_bus_oe(output_bus_oe), .cs_n(cs_n), .rd_n(rd_n), .rd_done(rd_done), .rd_word(rd_word));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Count edges until a watched output reaches a level; 0 = valid, 1 = ready, 2 = oe
  task automatic wait_sig(input int which, input logic lvl);
    logic v;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      v = (which == 0) ? result_valid_flag : (which == 1) ? word_ready_n : output_bus_oe;
    end while (v !== lvl && n < 400);
    if (n >= 400) check("wait timeout", 16'h0001, 16'h0000);
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Pulse one pin for k cycles; 0 = sync, 1 = cal request, 2 = cal clear, 3 = overrange
  task automatic pulse(input int which, input int k);
    @(posedge mclk);
    case (which) 0: sync_in <= 1'b1; 1: cal_req <= 1'b1; 2: cal_clear <= 1'b1; default: overrange <= 1'b1; endcase
    cycles(k);
    {sync_in, cal_req, cal_clear, overrange} <= 4'h0;
  endtask
  // Settle after a restart, then read the first word right after ready falls
  task automatic settle_read(input logic [15:0] exp, input string name);
    wait_sig(0, 1'b1);
    wait_sig(1, 1'b0);
    check("valid to ready", 16'(n), 16'h0040);
    host_read(exp, name);
  endtask
  task automatic host_read(input logic [15:0] exp, input string name);
    @(posedge mclk);
    rd_req <= 1'b1;
    n = 0;
    while (rd_done !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    check("read done", 16'(rd_done), 16'h0001);
    check(name, rd_word, exp);
    rd_req <= 1'b0;
    cycles(5);
    #1;
    check("bus released", 16'(output_bus_oe), 16'h0000);
    check("ready after read", 16'(word_ready_n), 16'h0001);
  endtask
  task automatic conclude;
    $display("Counts: comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    #300000;
    num_errors++;
    conclude();
  end
  initial begin
    cycles(5);
    reset_n <= 1'b1;
    pulse(0, 3);
    check("valid during sync", 16'(result_valid_flag), 16'h0000);
    wait_sig(0, 1'b1);
    check("release to valid", 16'(n >= SETTLE && n <= SETTLE + 3), 16'h0001);
    wait_sig(1, 1'b0);
    check("valid to ready", 16'(n), 16'h0040);
    $display("Test sync done");
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    check("unread ready pulse", 16'(n), 16'h0002);
    wait_sig(1, 1'b1);
    check("update period", 16'(n + 2), 16'h0040);
    wait_sig(1, 1'b0);
    host_read(16'h8001, "word 8001");
    @(posedge mclk);
    filter_word <= 16'h7FFE;
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    host_read(16'h7FFE, "word 7FFE");
    $display("Test read done");
    @(posedge mclk);
    port_sel <= 1'b0;
    cycles(4);
    rd_req <= 1'b1;
    cycles(70);
    check("serial bus idle", 16'(output_bus_oe), 16'h0000);
    check("serial ready high", 16'(word_ready_n), 16'h0001);
    rd_req <= 1'b0;
    port_sel <= 1'b1;
    $display("Test serial done");
    filter_word <= 16'h1234;
    pulse(1, 1);
    cycles(3);
    check("valid in cal", 16'(result_valid_flag), 16'h0000);
    settle_read(16'h0000, "calibrated word");
    check("no early discharge", 16'(mod_seen), 16'h0000);
    pulse(2, 3);
    cycles(3);
    check("clear drops valid", 16'(result_valid_flag), 16'h0000);
    check("integrator discharge", 16'(mod_seen), 16'h0001);
    settle_read(16'h1234, "uncalibrated word");
    $display("Test calibration done");
    pulse(3, 1);
    cycles(2);
    check("overrange drops valid", 16'(result_valid_flag), 16'h0000);
    wait_sig(0, 1'b1);
    check("overrange settle", 16'(n >= SETTLE - 3 && n <= SETTLE + 2), 16'h0001);
    $display("Test overrange done");
    conclude();
  end
endmodule // tb_top
